/* File: qcc_regs.svh */
/*
  register offsets, field positions and reset values of the quadrature
  counter control block, as define macros.
  assumes: included by bare name from the package and the core module.
*/
`ifndef QCC_REGS_SVH
`define QCC_REGS_SVH

// ----------------------------------------------------------------
// register word offsets
// ----------------------------------------------------------------
`define QCC_ADDR_W           3
`define QCC_DATA_W           16
`define QCC_OFS_CONTROL      3'h0
`define QCC_OFS_CONFIG       3'h1
`define QCC_OFS_POS_LOW      3'h2
`define QCC_OFS_POS_HIGH     3'h3
`define QCC_OFS_INDEX_CNT    3'h4
`define QCC_OFS_INTERVAL     3'h5
`define QCC_OFS_VELOCITY     3'h6
`define QCC_OFS_STATUS       3'h7

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define QCC_CTL_CCM_LO       0
`define QCC_CTL_CCM_HI       1
`define QCC_CTL_GATE_EN      2
`define QCC_CTL_POLARITY     3
`define QCC_CTL_PRESC_LO     4
`define QCC_CTL_PRESC_HI     6
`define QCC_CTL_RESET        7'h00

// ----------------------------------------------------------------
// configuration register fields
// ----------------------------------------------------------------
`define QCC_CFG_IDXMODE_LO   0
`define QCC_CFG_IDXMODE_HI   2
`define QCC_CFG_SWAP         3
`define QCC_CFG_A_POL        4
`define QCC_CFG_B_POL        5
`define QCC_CFG_IMV_LO       6
`define QCC_CFG_IMV_HI       7
`define QCC_CFG_EXT_DIR      8
`define QCC_CFG_RESET        9'h000

// ----------------------------------------------------------------
// prescaler
// ----------------------------------------------------------------
`define QCC_PRESC_W          3
`define QCC_PRESC_CNT_W      7

`endif

/* File: qcc_pkg.sv */
/*
  types shared by the quadrature counter control modules.
  assumes: qcc_regs.svh is on the include path.
*/
`include "qcc_regs.svh"

package qcc_pkg;

  // counting mode field
  typedef enum logic [1:0]
  {
    QCC_CCM_QUAD     = 2'h0,
    QCC_CCM_EXT_DIR  = 2'h1,
    QCC_CCM_EXT_CLK  = 2'h2,
    QCC_CCM_TIMER    = 2'h3
  } qcc_ccm_type;

  // index event handling
  typedef enum logic [2:0]
  {
    QCC_IDX_NONE        = 3'h0,
    QCC_IDX_RESET_MATCH = 3'h1
  } qcc_idx_mode_type;

endpackage

/* File: qcc_count_if.sv */
/*
  carrier between the core, the prescaler and the phase decoder.
  assumes: all parties run on the same clock.
*/
`timescale 1ns/10ps

interface qcc_count_if;
  logic tick;
  logic phase_a;
  logic phase_b;
  logic step;
  logic step_up;

  modport presc
  (
    output tick
  );
  modport dec
  (
    input  tick,
    input  phase_a,
    input  phase_b,
    output step,
    output step_up
  );
endinterface

/* File: qcc_prescaler.sv */
/*
  power of two divider: one tick every 2^code clocks.
  assumes: code may change at any time; the next tick then follows the new mask.
*/
`timescale 1ns/10ps

module qcc_prescaler
  import qcc_pkg::*;
#(
  parameter int PRESC_W = `QCC_PRESC_W,
  parameter int CNT_W   = `QCC_PRESC_CNT_W
)
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // divider select
  input  wire logic [PRESC_W-1:0] code,
  // tick out
  qcc_count_if.presc              cif
);

  if (CNT_W != (1 << PRESC_W) - 1)
    $error("qcc_prescaler: CNT_W must be 2^PRESC_W - 1");

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] mask;

  // code 0 gives an all-zero mask, so every clock ticks
  assign mask = CNT_W'((1 << code) - 1);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + 1'b1;
  end

  assign cif.tick = ((cnt_reg & mask) == mask);

endmodule

/* File: qcc_phase_decoder.sv */
/*
  x4 quadrature decoder: one step on every tick sample where exactly one phase has an edge.
  assumes: phases already swapped and polarity corrected, sampled on tick.
*/
`timescale 1ns/10ps

module qcc_phase_decoder
  import qcc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // phases in, steps out
  qcc_count_if.dec  cif
);

  logic prev_a_reg;
  logic prev_b_reg;
  logic step_reg;
  logic up_reg;
  logic one_change;

  // both phases moving at once has no direction; such a sample is dropped
  assign one_change = (cif.phase_a ^ prev_a_reg) ^ (cif.phase_b ^ prev_b_reg);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prev_a_reg <= 1'b0;
      prev_b_reg <= 1'b0;
    end
    else if (cif.tick)
    begin
      prev_a_reg <= cif.phase_a;
      prev_b_reg <= cif.phase_b;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      step_reg <= 1'b0;
      up_reg   <= 1'b0;
    end
    else
    begin
      step_reg <= cif.tick && one_change;
      // a leading b counts up
      up_reg   <= cif.phase_a ^ prev_b_reg;
    end
  end

  assign cif.step    = step_reg;
  assign cif.step_up = up_reg;

endmodule

/* File: qcc_core.sv */
/*
  quadrature counter control core: mode select, prescaler, direction,
  gating, index match reset and the position, index, interval and
  velocity counters, with a plain register port.
  assumes: all inputs synchronous to clk; register strobes one cycle,
  never both at once; read data is valid the cycle after the strobe.
*/
// Decided for this implementation: the address map and the plain strobed port.
// Functional notes
// - prescale code divides counter clock 1 to 128
// - polarity bit selects default count direction
// - gate enable lets gate input stop position
// - mode 11 counts prescaled internal clock
// - mode 10 counts external clock edges
// - mode 01 external clock, external direction
// - mode 00 x4 quadrature from phases
// - modes 10/11 timers, index mode ignored
// - quadrature index match clears position counter
// - match uses swapped, polarity corrected phases
`timescale 1ns/10ps
`include "qcc_regs.svh"

module qcc_core
  import qcc_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // register port
  input  wire logic [`QCC_ADDR_W-1:0] reg_addr,
  input  wire logic [`QCC_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`QCC_DATA_W-1:0] reg_rdata,
  // encoder side
  input  wire logic                   phase_a_input,
  input  wire logic                   phase_b_input,
  input  wire logic                   index_input,
  input  wire logic                   gate_input,
  input  wire logic                   ext_count_input,
  input  wire logic                   ext_updown_input,
  // counter view
  output logic      [31:0]            position_count,
  output logic                        count_up,
  output logic                        index_match_hit
);

  // ----------------------------------------------------------------
  // control and configuration registers
  // ----------------------------------------------------------------
  logic [`QCC_PRESC_W-1:0] counter_clock_prescale_reg;
  logic                    count_direction_polarity_reg;
  logic                    external_gate_enable_reg;
  qcc_ccm_type             counter_control_mode_reg;
  qcc_idx_mode_type        index_event_mode_reg;
  logic                    phase_swap_reg;
  logic                    phase_a_polarity_reg;
  logic                    phase_b_polarity_reg;
  logic [1:0]              index_match_value_reg;
  logic                    ext_dir_enable_reg;

  logic wr_control;
  logic wr_config;
  logic wr_pos_low;
  logic wr_pos_high;

  assign wr_control  = reg_wr && (reg_addr == `QCC_OFS_CONTROL);
  assign wr_config   = reg_wr && (reg_addr == `QCC_OFS_CONFIG);
  assign wr_pos_low  = reg_wr && (reg_addr == `QCC_OFS_POS_LOW);
  assign wr_pos_high = reg_wr && (reg_addr == `QCC_OFS_POS_HIGH);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      counter_clock_prescale_reg   <= '0;
      count_direction_polarity_reg <= 1'b0;
      external_gate_enable_reg     <= 1'b0;
      counter_control_mode_reg     <= QCC_CCM_QUAD;
    end
    else if (wr_control)
    begin
      counter_clock_prescale_reg   <= reg_wdata[`QCC_CTL_PRESC_HI:`QCC_CTL_PRESC_LO];
      count_direction_polarity_reg <= reg_wdata[`QCC_CTL_POLARITY];
      external_gate_enable_reg     <= reg_wdata[`QCC_CTL_GATE_EN];
      counter_control_mode_reg     <= qcc_ccm_type'(reg_wdata[`QCC_CTL_CCM_HI:`QCC_CTL_CCM_LO]);
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      index_event_mode_reg  <= QCC_IDX_NONE;
      phase_swap_reg        <= 1'b0;
      phase_a_polarity_reg  <= 1'b0;
      phase_b_polarity_reg  <= 1'b0;
      index_match_value_reg <= 2'h0;
      ext_dir_enable_reg    <= 1'b0;
    end
    else if (wr_config)
    begin
      index_event_mode_reg  <= qcc_idx_mode_type'(reg_wdata[`QCC_CFG_IDXMODE_HI:`QCC_CFG_IDXMODE_LO]);
      phase_swap_reg        <= reg_wdata[`QCC_CFG_SWAP];
      phase_a_polarity_reg  <= reg_wdata[`QCC_CFG_A_POL];
      phase_b_polarity_reg  <= reg_wdata[`QCC_CFG_B_POL];
      index_match_value_reg <= reg_wdata[`QCC_CFG_IMV_HI:`QCC_CFG_IMV_LO];
      ext_dir_enable_reg    <= reg_wdata[`QCC_CFG_EXT_DIR];
    end
  end

  // ----------------------------------------------------------------
  // prescaler and phase decoder
  // ----------------------------------------------------------------
  qcc_count_if cif ();

  qcc_prescaler #(
    .PRESC_W (`QCC_PRESC_W),
    .CNT_W   (`QCC_PRESC_CNT_W)
  ) u_presc (
    .clk  (clk),
    .rstn (rstn),
    .code (counter_clock_prescale_reg),
    .cif  (cif.presc)
  );

  qcc_phase_decoder u_dec (
    .clk  (clk),
    .rstn (rstn),
    .cif  (cif.dec)
  );

  // swap first, then invert each phase on its own
  logic phase_a_fix;
  logic phase_b_fix;

  assign phase_a_fix = (phase_swap_reg ? phase_b_input : phase_a_input) ^ phase_a_polarity_reg;
  assign phase_b_fix = (phase_swap_reg ? phase_a_input : phase_b_input) ^ phase_b_polarity_reg;
  assign cif.phase_a = phase_a_fix;
  assign cif.phase_b = phase_b_fix;

  // ----------------------------------------------------------------
  // external clock and index edge detection, sampled on the tick
  // ----------------------------------------------------------------
  // the edge is only seen if the input holds across one tick period
  logic ext_prev_reg;
  logic index_prev_reg;
  logic ext_rise;
  logic index_rise;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_prev_reg   <= 1'b0;
      index_prev_reg <= 1'b0;
    end
    else if (cif.tick)
    begin
      ext_prev_reg   <= ext_count_input;
      index_prev_reg <= index_input;
    end
  end

  assign ext_rise   = cif.tick && ext_count_input && !ext_prev_reg;
  assign index_rise = cif.tick && index_input && !index_prev_reg;

  // ----------------------------------------------------------------
  // mode select: count event and direction
  // ----------------------------------------------------------------
  logic evt;
  logic evt_up;
  logic default_up;
  logic timer_mode;

  assign default_up = !count_direction_polarity_reg;
  assign timer_mode = (counter_control_mode_reg == QCC_CCM_EXT_CLK) ||
                      (counter_control_mode_reg == QCC_CCM_TIMER);

  always_comb
  begin
    evt    = 1'b0;
    evt_up = default_up;
    unique case (counter_control_mode_reg)
      QCC_CCM_QUAD:
      begin
        evt    = cif.step;
        evt_up = cif.step_up ^ count_direction_polarity_reg;
      end
      QCC_CCM_EXT_DIR:
      begin
        evt    = ext_rise;
        evt_up = ext_updown_input;
      end
      QCC_CCM_EXT_CLK:
      begin
        evt    = ext_rise;
        evt_up = ext_dir_enable_reg ? ext_updown_input : default_up;
      end
      QCC_CCM_TIMER:
      begin
        evt    = cif.tick;
        evt_up = ext_dir_enable_reg ? ext_updown_input : default_up;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // gating and index match
  // ----------------------------------------------------------------
  logic pos_evt;
  logic match_clear;

  assign pos_evt = evt && (!external_gate_enable_reg || gate_input);

  // index mode has no say in timer modes
  assign match_clear = (counter_control_mode_reg == QCC_CCM_QUAD) &&
                       (index_event_mode_reg == QCC_IDX_RESET_MATCH) &&
                       index_input &&
                       ({phase_a_fix, phase_b_fix} == index_match_value_reg);

  // ----------------------------------------------------------------
  // position counter
  // ----------------------------------------------------------------
  logic [31:0] position_count_reg;
  logic [31:0] position_count_next;

  always_comb
  begin
    position_count_next = position_count_reg;
    if (pos_evt)
      position_count_next = evt_up ? position_count_reg + 32'h1 : position_count_reg - 32'h1;
    if (wr_pos_low)
      position_count_next = {position_count_reg[31:16], reg_wdata};
    if (wr_pos_high)
      position_count_next = {reg_wdata, position_count_reg[15:0]};
    // the match clears both halves and wins over a same-cycle write
    if (match_clear)
      position_count_next = 32'h0;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      position_count_reg <= 32'h0;
    else
      position_count_reg <= position_count_next;
  end

  // ----------------------------------------------------------------
  // index, interval and velocity counters
  // ----------------------------------------------------------------
  logic [15:0] index_count_reg;
  logic [15:0] interval_reg;
  logic [15:0] velocity_reg;
  logic        idx_evt;
  logic        vel_read;

  // in timer modes the index counter times the same events as position, taken before the gate
  assign idx_evt  = timer_mode ? evt : index_rise;
  assign vel_read = reg_rd && (reg_addr == `QCC_OFS_VELOCITY);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      index_count_reg <= 16'h0;
    else if (idx_evt)
      index_count_reg <= evt_up ? index_count_reg + 16'h1 : index_count_reg - 16'h1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      interval_reg <= 16'h0;
    else if (cif.tick)
      interval_reg <= interval_reg + 16'h1;
  end

  // a read clears the velocity, but an event in that cycle is kept
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      velocity_reg <= 16'h0;
    else if (vel_read)
      velocity_reg <= pos_evt ? (evt_up ? 16'h1 : 16'hffff) : 16'h0;
    else if (pos_evt)
      velocity_reg <= evt_up ? velocity_reg + 16'h1 : velocity_reg - 16'h1;
  end

  // ----------------------------------------------------------------
  // direction and match outputs
  // ----------------------------------------------------------------
  logic count_up_reg;
  logic match_hit_reg;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      count_up_reg <= 1'b1;
    else if (pos_evt)
      count_up_reg <= evt_up;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      match_hit_reg <= 1'b0;
    else
      match_hit_reg <= match_clear;
  end

  assign position_count  = position_count_reg;
  assign count_up        = count_up_reg;
  assign index_match_hit = match_hit_reg;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [`QCC_DATA_W-1:0] rdata_next;
  logic [`QCC_DATA_W-1:0] rdata_reg;

  always_comb
  begin
    rdata_next = '0;
    unique case (reg_addr)
      `QCC_OFS_CONTROL:
        rdata_next = {9'h0, counter_clock_prescale_reg, count_direction_polarity_reg,
                      external_gate_enable_reg, counter_control_mode_reg};
      `QCC_OFS_CONFIG:
        rdata_next = {7'h0, ext_dir_enable_reg, index_match_value_reg, phase_b_polarity_reg,
                      phase_a_polarity_reg, phase_swap_reg, index_event_mode_reg};
      `QCC_OFS_POS_LOW:
        rdata_next = position_count_reg[15:0];
      `QCC_OFS_POS_HIGH:
        rdata_next = position_count_reg[31:16];
      `QCC_OFS_INDEX_CNT:
        rdata_next = index_count_reg;
      `QCC_OFS_INTERVAL:
        rdata_next = interval_reg;
      `QCC_OFS_VELOCITY:
        rdata_next = velocity_reg;
      `QCC_OFS_STATUS:
        rdata_next = {11'h0, gate_input, count_up_reg, index_input, phase_b_fix, phase_a_fix};
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_reg <= '0;
    else if (reg_rd)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= '0;
  end

  assign reg_rdata = rdata_reg;

endmodule

/* File: qcc_core_chk.sv */
/*
  concurrent checks on the ports of the quadrature counter control core.
  assumes: bound into qcc_core; single clock domain, async active-low reset.
*/
`timescale 1ns/10ps
`include "qcc_regs.svh"

module qcc_core_chk
(
  // clock and reset
  input wire logic                   clk,
  input wire logic                   rstn,
  // register port
  input wire logic [`QCC_ADDR_W-1:0] reg_addr,
  input wire logic [`QCC_DATA_W-1:0] reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [`QCC_DATA_W-1:0] reg_rdata,
  // encoder side
  input wire logic                   index_input,
  input wire logic                   gate_input,
  input wire logic                   ext_updown_input,
  // counter view
  input wire logic [31:0]            position_count,
  input wire logic                   count_up,
  input wire logic                   index_match_hit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic [6:0]  ctl_reg;
  logic [31:0] pos_d_reg;
  logic        idx_d_reg;
  logic        quiet_reg;
  logic        up1;
  logic        dn1;

  // shadow of the control register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ctl_reg <= 7'h00;
    else if (reg_wr && reg_addr == 3'h0)
      ctl_reg <= reg_wdata[6:0];
  end

  // quiet: no write or index clear can have moved the count
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pos_d_reg <= 32'h0;
      idx_d_reg <= 1'b0;
      quiet_reg <= 1'b0;
    end
    else
    begin
      pos_d_reg <= position_count;
      idx_d_reg <= index_input;
      quiet_reg <= !reg_wr && !index_input && !idx_d_reg;
    end
  end

  assign up1 = position_count == pos_d_reg + 32'h1;
  assign dn1 = position_count == pos_d_reg - 32'h1;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ctl_readback: assert property ($past(reg_rd) && $past(reg_addr) == 3'h0 |-> reg_rdata == {9'h0, ctl_reg})
    else $error("control readback differs from written fields");
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  a_hit_clears_pos: assert property (index_match_hit |-> position_count == 32'h0)
    else $error("index match pulse without cleared position");
  a_hit_needs_index: assert property (index_match_hit |-> $past(index_input))
    else $error("index match pulse without index input");
  a_timer_no_index: assert property ($past(ctl_reg[1]) |-> !index_match_hit)
    else $error("index clear in timer modes");
  a_single_step: assert property (quiet_reg |-> up1 || dn1 || position_count == pos_d_reg)
    else $error("position moved by more than one");
  a_up_sets_dir: assert property (quiet_reg && up1 |-> count_up)
    else $error("increment without up direction");
  a_down_clears_dir: assert property (quiet_reg && dn1 |-> !count_up)
    else $error("decrement with up direction");
  a_gate_freezes: assert property ($past(ctl_reg[2]) && !$past(gate_input) && quiet_reg
                                   |-> $stable(position_count))
    else $error("position counted while gated off");
  a_ext_dir_up: assert property ($past(ctl_reg[1:0]) == 2'h1 && $past(ext_updown_input)
                                 && quiet_reg |-> !dn1)
    else $error("counted down with external direction up");

  c_index_clear: cover property (index_match_hit);
  c_dir_down: cover property ($fell(count_up));
  c_timer_count: cover property (ctl_reg[1:0] == 2'h3 && $changed(position_count));
endmodule

bind qcc_core qcc_core_chk i_chk
(
  .clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .index_input, .gate_input, .ext_updown_input, .position_count, .count_up, .index_match_hit
);

/* File: qcc_enc_model.sv */
/*
  behavioural incremental encoder: gray-coded phases and an external count line.
  assumes: tasks are called from the bench; lines change by nba after a clock edge.
*/
`timescale 1ns/10ps

module qcc_enc_model
(
  // clock
  input wire logic clk,
  // encoder lines
  output logic     phase_a,
  output logic     phase_b,
  output logic     ext_count
);
  logic [1:0] pos_reg;

  initial
  begin
    pos_reg   = 2'h0;
    phase_a   = 1'b0;
    phase_b   = 1'b0;
    ext_count = 1'b0;
  end

  // one quadrature edge; a leads b when moving up
  task automatic step(input logic up);
    @(posedge clk);
    pos_reg = up ? pos_reg + 2'h1 : pos_reg - 2'h1;
    phase_a <= pos_reg[1] ^ pos_reg[0];
    phase_b <= pos_reg[1];
    // hold several ticks so the counter clock is well above the edge rate
    repeat (3) @(posedge clk);
  endtask

  task automatic pulse();
    @(posedge clk);
    ext_count <= 1'b1;
    repeat (2) @(posedge clk);
    ext_count <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
endmodule

/* File: quadrature_counter_control_test.sv */
/*
  self-checking bench of the quadrature counter control core.
  assumes: qcc_core_chk is bound in; encoder model drives phases and count line.
*/
`timescale 1ns/10ps
`include "qcc_regs.svh"

module quadrature_counter_control_test;
  typedef struct packed {
    logic [15:0] ctl;
    logic [3:0]  n;
    logic        up;
    logic        gate;
    logic [15:0] exp;
    logic        chk_up;
    logic        exp_up;
  } qcc_row_type;

  logic                   clk;
  logic                   rstn;
  logic [`QCC_ADDR_W-1:0] reg_addr;
  logic [`QCC_DATA_W-1:0] reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [`QCC_DATA_W-1:0] reg_rdata;
  logic                   phase_a_input;
  logic                   phase_b_input;
  logic                   index_input;
  logic                   gate_input;
  logic                   ext_count_input;
  logic                   ext_updown_input;
  logic [31:0]            position_count;
  logic                   count_up;
  logic                   index_match_hit;
  logic [31:0]            v0;
  logic                   fa;
  logic                   fb;
  logic                   clr;
  int                     n_mismatch;
  int                     samples_checked;
  int                     n_hits;
  int                     hits_before;

  // ----------------------------------------------------------------
  // ordinary cases: control, steps, direction, gate, expected count
  // ----------------------------------------------------------------
  qcc_row_type rows [9] = '{
    '{16'h0000, 4'h4, 1'b1, 1'b0, 16'h0004, 1'b1, 1'b1},
    '{16'h0008, 4'h4, 1'b1, 1'b0, 16'hfffc, 1'b1, 1'b0},
    '{16'h0000, 4'h3, 1'b0, 1'b0, 16'hfffd, 1'b1, 1'b0},
    '{16'h0004, 4'h4, 1'b1, 1'b0, 16'h0000, 1'b0, 1'b0},
    '{16'h0004, 4'h4, 1'b1, 1'b1, 16'h0004, 1'b1, 1'b1},
    '{16'h0001, 4'h5, 1'b1, 1'b1, 16'h0005, 1'b1, 1'b1},
    '{16'h0001, 4'h5, 1'b0, 1'b1, 16'hfffb, 1'b1, 1'b0},
    '{16'h0002, 4'h3, 1'b1, 1'b1, 16'h0003, 1'b1, 1'b1},
    '{16'h000a, 4'h3, 1'b1, 1'b1, 16'hfffd, 1'b1, 1'b0}
  };

  qcc_core i_dut
  (
    .clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .phase_a_input, .phase_b_input, .index_input, .gate_input, .ext_count_input,
    .ext_updown_input, .position_count, .count_up, .index_match_hit
  );

  qcc_enc_model i_enc
  (
    .clk       (clk),
    .phase_a   (phase_a_input),
    .phase_b   (phase_b_input),
    .ext_count (ext_count_input)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (index_match_hit === 1'b1)
      n_hits <= n_hits + 1;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 check({16'h0, reg_rdata}, {16'h0, exp}, "register read");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // the run needs about 2700 cycles
  initial
  begin
    #200000;
    n_mismatch++;
    tally_and_finish;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    n_mismatch = 0;
    samples_checked = 0;
    n_hits = 0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    index_input = 1'b0;
    gate_input = 1'b0;
    ext_updown_input = 1'b0;
    rstn = 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 check(position_count, 32'h0, "reset position");
    check({31'h0, count_up}, 32'h1, "reset direction");
    reg_read(3'h0, 16'h0000);
    reg_read(3'h1, 16'h0000);
    // reserved bits must read back as zero
    reg_write(3'h0, 16'hffff);
    reg_read(3'h0, 16'h007f);
    reg_write(3'h1, 16'hffff);
    reg_read(3'h1, 16'h01ff);
    reg_write(3'h1, 16'h0000);
    foreach (rows[i])
    begin
      reg_write(3'h0, rows[i].ctl);
      gate_input <= rows[i].gate;
      ext_updown_input <= rows[i].up;
      reg_write(3'h2, 16'h0000);
      reg_write(3'h3, 16'h0000);
      repeat (rows[i].n)
        if (rows[i].ctl[1:0] == 2'h0)
          i_enc.step(rows[i].up);
        else
          i_enc.pulse();
      repeat (4) @(posedge clk);
      #1 check(position_count, {{16{rows[i].exp[15]}}, rows[i].exp}, "position");
      reg_read(3'h2, rows[i].exp);
      reg_read(3'h3, {16{rows[i].exp[15]}});
      if (rows[i].chk_up)
        check({31'h0, count_up}, {31'h0, rows[i].exp_up}, "direction");
    end
    // timer at every prescale code; external direction up on odd codes, down on even
    reg_write(3'h1, 16'h0100);
    for (int p = 0; p < 8; p++)
    begin
      reg_write(3'h0, {9'h000, p[2:0], 4'h3});
      ext_updown_input <= p[0];
      repeat (3) @(posedge clk);
      #1 v0 = position_count;
      repeat (256) @(posedge clk);
      #1 check(position_count - v0, p[0] ? 32'h100 >> p : 32'h0 - (32'h100 >> p), "timer ticks");
    end
    // index match over every swap and inversion setting, then in a timer mode
    reg_write(3'h0, 16'h0000);
    i_enc.step(1'b1);
    for (int k = 0; k < 16; k++)
    begin
      fa = (k[0] ? phase_b_input : phase_a_input) ^ k[1];
      fb = (k[0] ? phase_a_input : phase_b_input) ^ k[2];
      clr = !k[3] && {fa, fb} == 2'b10;
      reg_write(3'h0, k[3] ? 16'h0002 : 16'h0000);
      reg_write(3'h1, {8'h00, 2'b10, k[2:0], 3'h1});
      reg_write(3'h2, 16'h0005);
      reg_write(3'h3, 16'h0000);
      hits_before = n_hits;
      index_input <= 1'b1;
      repeat (3) @(posedge clk);
      index_input <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check(position_count, clr ? 32'h0 : 32'h5, "index clear");
      check({31'h0, n_hits != hits_before}, {31'h0, clr}, "index pulse");
    end
    tally_and_finish;
  end
endmodule
